/* rtl/fmtd_consts.vh */
// Constants for the fax/modem tone detector
`ifndef FMTD_CONSTS_VH
`define FMTD_CONSTS_VH
`define FMTD_CLK_MHZ           250
`define FMTD_SAMPLE_DIV        31250
`define FMTD_MS_TICKS          250000
`define FMTD_RECOG_MAX_MS      4000
`define FMTD_RECOG_BRK_MAX_MS  1000
`define FMTD_END_MAX_MS        1000
`define FMTD_END_BRK_MAX_MS    255
`define FMTD_RECOG_RST_MS      304
`define FMTD_RECOG_BRK_RST_MS  100
`define FMTD_END_RST_MS        256
`define FMTD_END_BRK_RST_MS    100
`define FMTD_RECOG_RST         8'h13
`define FMTD_RECOG_BRK_RST     8'h19
`define FMTD_END_RST           8'h40
`define FMTD_END_BRK_RST       8'h64
// Q15 cosine of 2100 Hz at 8 kHz; Q15 pole radii for 60 Hz and 230 Hz
`define FMTD_ROM_BP_A1         16'hF5F5
`define FMTD_ROM_BP_R          16'h7D05
`define FMTD_ROM_BS_R          16'h74F2
// Ceiling sits 12 dB above floor
`define FMTD_ROM_CEIL          16'h0394
`define FMTD_ROM_FLOOR         16'h00E5
`define FMTD_INT_SHIFT         5
`endif

/* rtl/fmtd_tone_detector.v */
// Per-channel fax/modem tone detector
`timescale 1ns/1ps
`include "fmtd_consts.vh"

module fmtd_tone_detector #(
  parameter integer SAMPLE_DIV   = `FMTD_SAMPLE_DIV,
  parameter integer MS_TICKS     = `FMTD_MS_TICKS,
  parameter integer RECOG_MAX_MS = `FMTD_RECOG_MAX_MS,
  parameter integer RBRK_MAX_MS  = `FMTD_RECOG_BRK_MAX_MS,
  parameter integer END_MAX_MS   = `FMTD_END_MAX_MS,
  parameter integer EBRK_MAX_MS  = `FMTD_END_BRK_MAX_MS
) (
  input  wire        clk_sys_in,
  input  wire        reset_n_in,
  input  wire        tone_detect_enable_in,
  input  wire        tone_detect_source_in,
  input  wire        coefficient_source_select_in,
  input  wire [15:0] rx_sample_in,
  input  wire [15:0] tx_sample_in,
  input  wire        cfg_write_in,
  input  wire [1:0]  cfg_addr_in,
  input  wire [7:0]  cfg_wdata_in,
  input  wire        coef_write_in,
  input  wire [2:0]  coef_addr_in,
  input  wire [15:0] coef_wdata_in,
  output reg  [7:0]  recognition_time_field_out,
  output reg  [7:0]  recognition_break_field_out,
  output reg  [7:0]  end_time_field_out,
  output reg  [7:0]  end_break_field_out,
  output reg         tone_detected_flag_out,
  output reg         tone_irq_out
);

  // Timer tick: one ms-unit; each field step spans a per-field number of ms-units
  localparam integer RT_STEP_MS  = (RECOG_MAX_MS + 254) / 255;
  localparam integer RB_STEP_MS  = (RBRK_MAX_MS + 254) / 255;
  localparam integer ET_STEP_MS  = (END_MAX_MS + 254) / 255;
  localparam integer EB_STEP_MS  = (EBRK_MAX_MS + 254) / 255;

  // Coefficient RAM: 0 centre cosine, 1 bp radius, 2 bs radius, 3 ceiling, 4 floor
  reg  [15:0] coef_ram [0:4];
  reg  [31:0] samp_cnt_q;
  reg  [31:0] ms_cnt_q;
  reg         samp_en_q;
  reg         ms_en_q;
  reg  [15:0] in_q;
  reg  signed [17:0] bp_y1_q, bp_y2_q, bs_y1_q, bs_y2_q, x1_q, x2_q;
  reg  [23:0] in_lvl_q, out_lvl_q;
  reg  [15:0] run_q, brk_q;

  wire sel_rom = coefficient_source_select_in;
  // Shared cosine keeps both filters on one centre
  wire [15:0] cos_w = sel_rom ? `FMTD_ROM_BP_A1 : coef_ram[0];
  wire signed [17:0] a1   = $signed({{2{cos_w[15]}}, cos_w});
  wire signed [17:0] bp_r = $signed({2'b00, sel_rom ? `FMTD_ROM_BP_R : coef_ram[1]});
  wire signed [17:0] bs_r = $signed({2'b00, sel_rom ? `FMTD_ROM_BS_R : coef_ram[2]});
  wire [15:0] ceil_t = sel_rom ? `FMTD_ROM_CEIL  : coef_ram[3];
  wire [15:0] flr_t  = sel_rom ? `FMTD_ROM_FLOOR : coef_ram[4];

  // Unity peak gain resonator: av cosine, rv pole radius (Q15)
  // y = (1-r*r)/2*(x - x2) + 2*r*av*y1 - r*r*y2
  function signed [17:0] fmtd_res;
    input signed [17:0] xv, x2v, y1v, y2v, av, rv;
    reg signed [47:0] rc;
    reg signed [47:0] rr;
    reg signed [47:0] acc;
    begin
      rc  = ($signed({{30{av[17]}}, av}) * $signed({{30{rv[17]}}, rv})) >>> 15;
      rr  = ($signed({{30{rv[17]}}, rv}) * $signed({{30{rv[17]}}, rv})) >>> 15;
      acc = ($signed({{30{xv[17]}}, xv}) - $signed({{30{x2v[17]}}, x2v}))
          * ((48'sh8000 - rr) >>> 1);
      acc = acc + (($signed({{30{y1v[17]}}, y1v}) * rc) <<< 1)
          - ($signed({{30{y2v[17]}}, y2v}) * rr);
      fmtd_res = acc[32:15];
    end
  endfunction

  function [17:0] fmtd_abs;
    input signed [17:0] v;
    begin
      fmtd_abs = v[17] ? (~v + 18'h00001) : v;
    end
  endfunction

  wire signed [17:0] x0 = $signed({{2{in_q[15]}}, in_q});
  wire signed [17:0] bp_n = fmtd_res(x0, x2_q, bp_y1_q, bp_y2_q, a1, bp_r);
  // Bandstop = input minus its own narrow resonance
  wire signed [17:0] bs_res = fmtd_res(x0, x2_q, bs_y1_q, bs_y2_q, a1, bs_r);
  wire signed [17:0] bs_n = x0 - bs_res;
  wire [15:0] in_lvl  = in_lvl_q[23:8];
  wire [15:0] out_lvl = out_lvl_q[23:8];
  wire cond_ok = (in_lvl > out_lvl) && (in_lvl > flr_t) && (in_lvl < ceil_t);

  wire [15:0] rt_lim = recognition_time_field_out  * RT_STEP_MS[7:0];
  wire [15:0] rb_lim = recognition_break_field_out * RB_STEP_MS[7:0];
  wire [15:0] et_lim = end_time_field_out          * ET_STEP_MS[7:0];
  wire [15:0] eb_lim = end_break_field_out         * EB_STEP_MS[7:0];

  always @(posedge clk_sys_in) begin
    if (coef_write_in && coef_addr_in < 3'h5) begin
      coef_ram[coef_addr_in] <= coef_wdata_in;
    end
  end

  always @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      recognition_time_field_out  <= `FMTD_RECOG_RST;
      recognition_break_field_out <= `FMTD_RECOG_BRK_RST;
      end_time_field_out          <= `FMTD_END_RST;
      end_break_field_out         <= `FMTD_END_BRK_RST;
    end else if (cfg_write_in) begin
      case (cfg_addr_in)
        2'h0: recognition_time_field_out  <= cfg_wdata_in;
        2'h1: recognition_break_field_out <= cfg_wdata_in;
        2'h2: end_time_field_out          <= cfg_wdata_in;
        default: end_break_field_out      <= cfg_wdata_in;
      endcase
    end
  end

  always @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      samp_cnt_q <= 32'h0;
      ms_cnt_q   <= 32'h0;
      samp_en_q  <= 1'b0;
      ms_en_q    <= 1'b0;
    end else begin
      samp_en_q  <= (samp_cnt_q == SAMPLE_DIV - 1);
      samp_cnt_q <= (samp_cnt_q == SAMPLE_DIV - 1) ? 32'h0 : samp_cnt_q + 32'h1;
      ms_en_q    <= (ms_cnt_q == MS_TICKS - 1);
      ms_cnt_q   <= (ms_cnt_q == MS_TICKS - 1) ? 32'h0 : ms_cnt_q + 32'h1;
    end
  end

  // Filters and integrators
  always @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      in_q      <= 16'h0;
      x1_q      <= 18'h0;
      x2_q      <= 18'h0;
      bp_y1_q   <= 18'h0;
      bp_y2_q   <= 18'h0;
      bs_y1_q   <= 18'h0;
      bs_y2_q   <= 18'h0;
      in_lvl_q  <= 24'h0;
      out_lvl_q <= 24'h0;
    end else if (!tone_detect_enable_in) begin
      in_q      <= 16'h0;
      x1_q      <= 18'h0;
      x2_q      <= 18'h0;
      bp_y1_q   <= 18'h0;
      bp_y2_q   <= 18'h0;
      bs_y1_q   <= 18'h0;
      bs_y2_q   <= 18'h0;
      in_lvl_q  <= 24'h0;
      out_lvl_q <= 24'h0;
    end else if (samp_en_q) begin
      in_q <= tone_detect_source_in ? tx_sample_in : rx_sample_in;
      x2_q <= x1_q;
      x1_q <= x0;
      bp_y2_q <= bp_y1_q;
      bp_y1_q <= bp_n;
      bs_y2_q <= bs_y1_q;
      bs_y1_q <= bs_res;
      // Leaky integrators of rectified outputs
      in_lvl_q  <= in_lvl_q - (in_lvl_q >> `FMTD_INT_SHIFT)
                 + {6'h0, fmtd_abs(bp_n)};
      out_lvl_q <= out_lvl_q - (out_lvl_q >> `FMTD_INT_SHIFT)
                 + {6'h0, fmtd_abs(bs_n)};
    end
  end

  // Qualification: run counts elapsed recognition or end time, breaks included; brk counts current break
  always @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      run_q <= 16'h0;
      brk_q <= 16'h0;
      tone_detected_flag_out <= 1'b0;
      tone_irq_out <= 1'b0;
    end else if (!tone_detect_enable_in) begin
      run_q <= 16'h0;
      brk_q <= 16'h0;
      tone_detected_flag_out <= 1'b0;
      tone_irq_out <= 1'b0;
    end else begin
      tone_irq_out <= 1'b0;
      if (ms_en_q) begin
        if (!tone_detected_flag_out) begin
          if (cond_ok) begin
            brk_q <= 16'h0;
            if (run_q >= rt_lim) begin
              tone_detected_flag_out <= 1'b1;
              tone_irq_out <= 1'b1;
              run_q <= 16'h0;
            end else begin
              run_q <= run_q + 16'h1;
            end
          end else if (brk_q >= rb_lim) begin
            run_q <= 16'h0;
            brk_q <= 16'h0;
          end else begin
            brk_q <= brk_q + 16'h1;
            run_q <= run_q + 16'h1;
          end
        end else begin
          if (!cond_ok) begin
            brk_q <= 16'h0;
            if (run_q >= et_lim) begin
              tone_detected_flag_out <= 1'b0;
              run_q <= 16'h0;
            end else begin
              run_q <= run_q + 16'h1;
            end
          end else if (brk_q >= eb_lim) begin
            run_q <= 16'h0;
            brk_q <= 16'h0;
          end else begin
            brk_q <= brk_q + 16'h1;
            run_q <= run_q + 16'h1;
          end
        end
      end
    end
  end

endmodule // fmtd_tone_detector

/* verif/fmtd_tone_detector_asserts.sv */
// Assertion checker for the fax/modem tone detector
`timescale 1ns/1ps
module fmtd_tone_detector_asserts (
  input wire       clk_sys_in,
  input wire       reset_n_in,
  input wire       tone_detect_enable_in,
  input wire       cfg_write_in,
  input wire [1:0] cfg_addr_in,
  input wire [7:0] cfg_wdata_in,
  input wire [7:0] recognition_time_field_out,
  input wire [7:0] recognition_break_field_out,
  input wire [7:0] end_time_field_out,
  input wire [7:0] end_break_field_out,
  input wire       tone_detected_flag_out,
  input wire       tone_irq_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!reset_n_in);
  property p_wr_rt;
    cfg_write_in && cfg_addr_in == 2'h0 |=> recognition_time_field_out == $past(cfg_wdata_in);
  endproperty
  a_wr_rt: assert property (p_wr_rt) else $error("time field write lost");
  property p_wr_rb;
    cfg_write_in && cfg_addr_in == 2'h1 |=> recognition_break_field_out == $past(cfg_wdata_in);
  endproperty
  a_wr_rb: assert property (p_wr_rb) else $error("break field write lost");
  property p_wr_et;
    cfg_write_in && cfg_addr_in == 2'h2 |=> end_time_field_out == $past(cfg_wdata_in);
  endproperty
  a_wr_et: assert property (p_wr_et) else $error("end field write lost");
  property p_wr_eb;
    cfg_write_in && cfg_addr_in == 2'h3 |=> end_break_field_out == $past(cfg_wdata_in);
  endproperty
  a_wr_eb: assert property (p_wr_eb) else $error("end break write lost");
  property p_hold;
    !cfg_write_in |=> $stable(recognition_time_field_out) && $stable(end_break_field_out);
  endproperty
  a_hold: assert property (p_hold) else $error("field changed unwritten");
  property p_irq_set;
    tone_irq_out |-> tone_detected_flag_out && !$past(tone_detected_flag_out);
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("irq without flag set");
  property p_irq_one;
    tone_irq_out |=> !tone_irq_out;
  endproperty
  a_irq_one: assert property (p_irq_one) else $error("irq too long");
  property p_rise;
    $rose(tone_detected_flag_out) |-> tone_irq_out && $past(tone_detect_enable_in);
  endproperty
  a_rise: assert property (p_rise) else $error("flag rose without irq");
  property p_dis;
    !tone_detect_enable_in |=> !tone_detected_flag_out [*2];
  endproperty
  a_dis: assert property (p_dis) else $error("flag set while disabled");
endmodule // fmtd_tone_detector_asserts

bind fmtd_tone_detector fmtd_tone_detector_asserts u_chk (
  .clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
  .tone_detect_enable_in(tone_detect_enable_in), .cfg_write_in(cfg_write_in),
  .cfg_addr_in(cfg_addr_in), .cfg_wdata_in(cfg_wdata_in),
  .recognition_time_field_out(recognition_time_field_out),
  .recognition_break_field_out(recognition_break_field_out),
  .end_time_field_out(end_time_field_out), .end_break_field_out(end_break_field_out),
  .tone_detected_flag_out(tone_detected_flag_out), .tone_irq_out(tone_irq_out));

/* verif/fmtd_tone_detector_tb.sv */
// Self-checking testbench for the fax/modem tone detector
`timescale 1ns/1ps
module fmtd_tone_detector_tb;
  reg         clk_sys_in = 1'b0, reset_n_in = 1'b0, en = 1'b0, src = 1'b0, csel = 1'b1;
  reg         cfg_write_in = 1'b0, coef_write_in = 1'b0;
  reg  [1:0]  cfg_addr_in = 2'h0;
  reg  [7:0]  cfg_wdata_in = 8'h00;
  reg  [2:0]  coef_addr_in = 3'h0;
  reg  [15:0] coef_wdata_in = 16'h0000, rx = 16'h0000, tx = 16'h0000;
  wire [7:0]  rt, rb, et, eb;
  wire        flag, irq;
  integer     n_mismatch = 0, tests_run = 0, cyc = 0;
  always #2 clk_sys_in = ~clk_sys_in;
  // Tone at 21/80 of the sample rate, one sample per four clocks
  function [15:0] tone_at(input integer n);
    integer v;
    begin
      v = $rtoi(7168.0 * $sin(6.2831853 * 21.0 * (n % 80) / 80.0));
      tone_at = v[15:0];
    end
  endfunction
  // Tone on the transmit path only, receive path silent
  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    tx  <= tone_at(cyc / 4);
  end
  fmtd_tone_detector #(.SAMPLE_DIV(4), .MS_TICKS(8)) uut (
    .clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .tone_detect_enable_in(en),
    .tone_detect_source_in(src), .coefficient_source_select_in(csel),
    .rx_sample_in(rx), .tx_sample_in(tx), .cfg_write_in(cfg_write_in),
    .cfg_addr_in(cfg_addr_in), .cfg_wdata_in(cfg_wdata_in), .coef_write_in(coef_write_in),
    .coef_addr_in(coef_addr_in), .coef_wdata_in(coef_wdata_in),
    .recognition_time_field_out(rt), .recognition_break_field_out(rb),
    .end_time_field_out(et), .end_break_field_out(eb),
    .tone_detected_flag_out(flag), .tone_irq_out(irq));
  task check(input [15:0] seen, input [15:0] exp);
    tests_run = tests_run + 1;
    if (seen !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Strobe stays high; caller lowers it after the last write
  task wr(input [1:0] a, input [7:0] d);
    @(posedge clk_sys_in);
    cfg_write_in <= 1'b1;
    cfg_addr_in <= a;
    cfg_wdata_in <= d;
  endtask
  task t_reset;
    #1;
    check(rt, 16'h0013);
    check(rb, 16'h0019);
    check(et, 16'h0040);
    check(eb, 16'h0064);
    check(flag, 16'h0000);
  endtask
  task t_write;
    wr(2'h0, 8'hFF);
    wr(2'h1, 8'h00);
    wr(2'h2, 8'hA5);
    wr(2'h3, 8'h5A);
    @(posedge clk_sys_in) cfg_write_in <= 1'b0;
    #1;
    check(rt, 16'h00FF);
    check(rb, 16'h0000);
    check(et, 16'h00A5);
    check(eb, 16'h005A);
  endtask
  task wr_coef(input [2:0] a, input [15:0] d);
    @(posedge clk_sys_in);
    coef_write_in <= 1'b1;
    coef_addr_in  <= a;
    coef_wdata_in <= d;
  endtask
  // Bounded wait for the flag to reach a level
  task wait_flag(input v, input integer lim);
    integer k;
    begin
      k = 0;
      while (flag !== v && k < lim) begin
        @(posedge clk_sys_in);
        #1;
        k = k + 1;
      end
    end
  endtask
  // Receive path selected and silent: no detection
  task t_source;
    wr(2'h0, 8'h00);
    en  <= 1'b1;
    src <= 1'b0;
    @(posedge clk_sys_in) cfg_write_in <= 1'b0;
    repeat (1500) @(posedge clk_sys_in);
    #1;
    check(flag, 16'h0000);
  endtask
  // RAM filters on the tone centre, floor above the tone level
  task t_coef_ram;
    wr_coef(3'h0, 16'hF5F5);
    wr_coef(3'h1, 16'h7D05);
    wr_coef(3'h2, 16'h74F2);
    wr_coef(3'h3, 16'h0400);
    wr_coef(3'h4, 16'h0300);
    @(posedge clk_sys_in);
    coef_write_in <= 1'b0;
    csel <= 1'b0;
    src  <= 1'b1;
    repeat (1500) @(posedge clk_sys_in);
    #1;
    check(flag, 16'h0000);
  endtask
  task t_detect;
    @(posedge clk_sys_in) csel <= 1'b1;
    wait_flag(1'b1, 3000);
    check(flag, 16'h0001);
    check(irq, 16'h0001);
    @(posedge clk_sys_in);
    #1;
    check(irq, 16'h0000);
    check(flag, 16'h0001);
    @(posedge clk_sys_in) en <= 1'b0;
    @(posedge clk_sys_in);
    #1;
    check(flag, 16'h0000);
    check(irq, 16'h0000);
  endtask
  task t_end;
    @(posedge clk_sys_in) en <= 1'b1;
    wait_flag(1'b1, 3000);
    check(flag, 16'h0001);
    wr(2'h2, 8'h01);
    wr(2'h3, 8'h00);
    @(posedge clk_sys_in);
    cfg_write_in <= 1'b0;
    src <= 1'b0;
    wait_flag(1'b0, 2000);
    check(flag, 16'h0000);
  endtask
  task print_verdict;
    if (n_mismatch == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #100000;
    n_mismatch = n_mismatch + 1;
    print_verdict;
  end
  initial begin
    repeat (3) @(posedge clk_sys_in);
    reset_n_in <= 1'b1;
    t_reset;
    t_write;
    t_source;
    t_coef_ram;
    t_detect;
    t_end;
    print_verdict;
  end
endmodule // fmtd_tone_detector_tb
